// [asm_pkg.sv]
package asm_pkg;
  localparam logic [5:0]  ASM_ADDR_STATUS   = 6'h01;
  localparam logic [5:0]  ASM_ADDR_MODE     = 6'h02;
  localparam logic [15:0] ASM_STATUS_RESET  = 16'h0500;
  localparam logic [15:0] ASM_MODE_RESET    = 16'h0510;
  // writable mode bits; reserved 15:14 and 7:5 stay zero
  localparam logic [15:0] ASM_MODE_WMASK    = 16'h3F1F;
  localparam int          ASM_B_LOCK        = 15;
  localparam int          ASM_B_RESYNC      = 14;
  localparam int          ASM_B_REGMAP      = 13;
  localparam int          ASM_B_CRCERR      = 12;
  localparam int          ASM_B_CRCTYPE     = 11;
  localparam int          ASM_B_RSTFLAG     = 10;
  localparam int          ASM_B_WLEN_HI     = 9;
  localparam int          ASM_B_WLEN_LO     = 8;
  localparam int          ASM_B_REGCRC_EN   = 13;
  localparam int          ASM_B_RXCRC_EN    = 12;
  localparam int          ASM_B_TIMEOUT     = 4;
  localparam int          ASM_B_SEL_HI      = 3;
  localparam int          ASM_B_SEL_LO      = 2;
  localparam int          ASM_B_FLOAT       = 1;
  localparam int          ASM_B_PULSE       = 0;
  localparam logic [1:0]  ASM_SEL_LAG       = 2'h0;
  localparam logic [1:0]  ASM_SEL_OR        = 2'h1;
  localparam int          ASM_NCH           = 3;
  localparam int          ASM_PULSE_NS      = 40;
  localparam int          ASM_CLK_NS        = 10;
  localparam int          ASM_PULSE_CYC     = (ASM_PULSE_NS + ASM_CLK_NS - 1)
                                              / ASM_CLK_NS;
endpackage

// [asm_status_mode.sv]
`timescale 1ns/10ps
// Summary of operation
// - status bit 15 shows interface lock
// - bit 14 set on every resync
// - bit 13 set when register checksum changes
// - bit 12 set on input checksum error
// - mode bit 11 picks checksum type, mirrored
// - reset flag set at reset, host clears
// - mode bits 9:8 select data word size
// - status 9:8 mirror word size
// - per-channel new-data flags at bits 2:0
// - register checksum only when mode bit 13
// - input checksum check only when bit 12
// - mode bits 3:2 pick ready-pin source
// - mode bit 1 floats idle ready pin
// - mode bit 0 selects low pulse format
module asm_status_mode
  import asm_pkg::*;
#(
  parameter int NCH = ASM_NCH
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // register access port
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [5:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  // core events and state, asynchronous to clk_i
  input  wire logic              lock_i,
  input  wire logic              resync_i,
  input  wire logic              regmap_crc_changed_i,
  input  wire logic              rx_crc_err_i,
  input  wire logic [NCH-1:0]    ch_new_i,
  input  wire logic [NCH-1:0]    ch_en_i,
  // mode controls to the core
  output logic                   regmap_crc_en_o,
  output logic                   rx_crc_check_en_o,
  output logic                   crc_type_o,
  output logic [1:0]             word_size_select_o,
  output logic                   timeout_en_o,
  // sample ready pin
  output logic                   sample_ready_pin_o,
  output logic                   sample_ready_pin_oe_o
);

  localparam int NIN = NCH + 4;

  logic [NIN-1:0] in_meta;
  logic [NIN-1:0] in_sync;
  logic [NIN-1:0] in_prev;
  logic [15:0]    mode;
  logic           resynced_flag;
  logic           regmap_flag;
  logic           crc_err_flag;
  logic           rst_flag;
  logic [NCH-1:0] ch_new_sample_flag;
  logic [7:0]     pulse_cnt;
  logic           pin_low;
  logic           ready_src;
  logic           ready_prev;
  logic [NCH-1:0] en_new;
  logic [NCH-1:0] ch_pend;
  logic [15:0]    status_word;

  // two-stage synchronisers; first stage only feeds the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_meta <= '0;
      in_sync <= '0;
      in_prev <= '0;
    end else begin
      in_meta <= {ch_new_i, lock_i, resync_i, regmap_crc_changed_i,
                  rx_crc_err_i};
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  wire logic           s_lock   = in_sync[3];
  wire logic           e_resync = in_sync[2] & ~in_prev[2];
  wire logic           e_regmap = in_sync[1] & ~in_prev[1];
  wire logic           e_crcerr = in_sync[0] & ~in_prev[0];
  wire logic [NCH-1:0] e_new    = in_sync[NIN-1:4] & ~in_prev[NIN-1:4];
  wire logic           wr_mode  = reg_wr_i && reg_addr_i == ASM_ADDR_MODE;
  wire logic           rd_stat  = reg_rd_i && reg_addr_i == ASM_ADDR_STATUS;

  // mode register; reserved bits forced low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= ASM_MODE_RESET;
    end else if (wr_mode) begin
      mode <= reg_wdata_i & ASM_MODE_WMASK;
    end
  end

  // sticky event flags cleared by a status read; set wins over clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resynced_flag <= 1'b0;
      regmap_flag   <= 1'b0;
      crc_err_flag  <= 1'b0;
    end else begin
      resynced_flag <= e_resync | (resynced_flag & ~rd_stat);
      regmap_flag   <= (e_regmap & mode[ASM_B_REGCRC_EN])
                       | (regmap_flag & ~rd_stat);
      crc_err_flag  <= (e_crcerr & mode[ASM_B_RXCRC_EN])
                       | (crc_err_flag & ~rd_stat);
    end
  end

  // reset flag: only a mode write with bit 10 low clears it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_flag <= 1'b1;
    end else if (wr_mode && !reg_wdata_i[ASM_B_RSTFLAG]) begin
      rst_flag <= 1'b0;
    end
  end

  // per-channel new-data flags, cleared when status is read
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ch_new_sample_flag[g] <= 1'b0;
        end else begin
          ch_new_sample_flag[g] <= e_new[g]
                                   | (ch_new_sample_flag[g] & ~rd_stat);
        end
      end
    end
  endgenerate

  always_comb begin
    status_word = '0;
    status_word[ASM_B_LOCK]    = s_lock;
    status_word[ASM_B_RESYNC]  = resynced_flag;
    status_word[ASM_B_REGMAP]  = regmap_flag;
    status_word[ASM_B_CRCERR]  = crc_err_flag;
    status_word[ASM_B_CRCTYPE] = mode[ASM_B_CRCTYPE];
    status_word[ASM_B_RSTFLAG] = rst_flag;
    status_word[ASM_B_WLEN_HI:ASM_B_WLEN_LO] =
      mode[ASM_B_WLEN_HI:ASM_B_WLEN_LO];
    status_word[NCH-1:0] = ch_new_sample_flag;
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ASM_ADDR_STATUS: reg_rdata_o <= status_word;
        ASM_ADDR_MODE:   reg_rdata_o <= mode;
        default:         reg_rdata_o <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      regmap_crc_en_o    <= 1'b0;
      rx_crc_check_en_o  <= 1'b0;
      crc_type_o         <= 1'b0;
      word_size_select_o <= ASM_MODE_RESET[ASM_B_WLEN_HI:ASM_B_WLEN_LO];
      timeout_en_o       <= ASM_MODE_RESET[ASM_B_TIMEOUT];
    end else begin
      regmap_crc_en_o    <= mode[ASM_B_REGCRC_EN];
      rx_crc_check_en_o  <= mode[ASM_B_RXCRC_EN];
      crc_type_o         <= mode[ASM_B_CRCTYPE];
      word_size_select_o <= mode[ASM_B_WLEN_HI:ASM_B_WLEN_LO];
      timeout_en_o       <= mode[ASM_B_TIMEOUT];
    end
  end

  // ready source; lagging = all enabled pending, leading = any new
  assign en_new  = e_new & ch_en_i;
  assign ch_pend = ch_new_sample_flag & ch_en_i;
  always_comb begin
    unique case (mode[ASM_B_SEL_HI:ASM_B_SEL_LO])
      ASM_SEL_LAG: ready_src = (ch_pend | en_new) == ch_en_i &&
                               ch_en_i != '0;
      ASM_SEL_OR:  ready_src = |(ch_pend | en_new);
      default:     ready_src = |en_new;
    endcase
  end

  // pin: low while ready (level) or fixed pulse; idle high or float
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_prev <= 1'b0;
      pulse_cnt  <= '0;
      pin_low    <= 1'b0;
    end else begin
      ready_prev <= ready_src;
      if (mode[ASM_B_PULSE]) begin
        if (ready_src && !ready_prev) begin
          pulse_cnt <= 8'(ASM_PULSE_CYC);
          pin_low   <= 1'b1;
        end else if (pulse_cnt > 8'h01) begin
          pulse_cnt <= pulse_cnt - 8'h01;
        end else begin
          pulse_cnt <= '0;
          pin_low   <= 1'b0;
        end
      end else begin
        pulse_cnt <= '0;
        pin_low   <= ready_src;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_ready_pin_oe_o <= 1'b0;
    end else begin
      sample_ready_pin_oe_o <= pin_low | ~mode[ASM_B_FLOAT];
    end
  end

  // driven high when idle so a non-floating pin never idles low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_ready_pin_o <= 1'b1;
    end else begin
      sample_ready_pin_o <= ~pin_low;
    end
  end

  property p_rstflag;
    @(posedge clk_i) disable iff (!rstn_i)
      (wr_mode && !reg_wdata_i[ASM_B_RSTFLAG]) |=> !rst_flag;
  endproperty
  a_rstflag: assert property (p_rstflag) else $error("rst flag kept");

  property p_resync;
    @(posedge clk_i) disable iff (!rstn_i)
      e_resync |=> resynced_flag;
  endproperty
  a_resync: assert property (p_resync) else $error("resync lost");

  property p_crcerr;
    @(posedge clk_i) disable iff (!rstn_i)
      (e_crcerr && !mode[ASM_B_RXCRC_EN] && !crc_err_flag) |=> !crc_err_flag;
  endproperty
  a_crcerr: assert property (p_crcerr) else $error("crc err gated");

  property p_regmap;
    @(posedge clk_i) disable iff (!rstn_i)
      (e_regmap && mode[ASM_B_REGCRC_EN]) |=> regmap_flag;
  endproperty
  a_regmap: assert property (p_regmap) else $error("regmap lost");

  property p_wlen;
    @(posedge clk_i) disable iff (!rstn_i)
      wr_mode |=> ##1 word_size_select_o ==
        $past(reg_wdata_i[ASM_B_WLEN_HI:ASM_B_WLEN_LO], 2);
  endproperty
  a_wlen: assert property (p_wlen) else $error("word size wrong");

  property p_float;
    @(posedge clk_i) disable iff (!rstn_i)
      (mode[ASM_B_FLOAT] && !pin_low) |=> !sample_ready_pin_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("pin not floated");

  property p_pulse;
    @(posedge clk_i) disable iff (!rstn_i)
      (mode[ASM_B_PULSE] && ready_src && !ready_prev) |=> pin_low;
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse");

  property p_lock;
    @(posedge clk_i) disable iff (!rstn_i)
      (rd_stat && reg_addr_i == ASM_ADDR_STATUS) |=>
        reg_rdata_o[ASM_B_LOCK] == $past(in_sync[3]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");

  property p_idle_high;
    @(posedge clk_i) disable iff (!rstn_i)
      (!mode[ASM_B_FLOAT] && !pin_low) |=>
        (sample_ready_pin_oe_o && sample_ready_pin_o);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle pin");

  property p_drive_low;
    @(posedge clk_i) disable iff (!rstn_i)
      pin_low |=> (sample_ready_pin_oe_o && !sample_ready_pin_o);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("not low");

  property p_newflag;
    @(posedge clk_i) disable iff (!rstn_i)
      (e_new != '0) |=> ((ch_new_sample_flag & $past(e_new)) == $past(e_new));
  endproperty
  a_newflag: assert property (p_newflag) else $error("flag lost");

  property p_rdclr;
    @(posedge clk_i) disable iff (!rstn_i)
      (rd_stat && !e_resync) |=> !resynced_flag;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("flag kept");

  property p_lag;
    @(posedge clk_i) disable iff (!rstn_i)
      (mode[ASM_B_SEL_HI:ASM_B_SEL_LO] == ASM_SEL_LAG &&
       (ch_pend | en_new) != ch_en_i) |-> !ready_src;
  endproperty
  a_lag: assert property (p_lag) else $error("early ready");

endmodule

// [asm_host_model.sv]
`timescale 1ns/10ps
module asm_host_model
  import asm_pkg::*;
(
  // register bus towards the block
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [5:0]       addr_o,
  output logic [15:0]      wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;

  // reserved mode bits always go out as zero
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = (a == ASM_ADDR_MODE) ? (d & ASM_MODE_WMASK) : d;
    @(negedge clk_i);
    wr_o = 1'b0;
    // released bus shows junk, not the old value
    {addr_o, wdata_o} = ~{addr_o, wdata_o};
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule

// [asm_status_mode_tb.sv]
`timescale 1ns/10ps
module asm_status_mode_tb
  import asm_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        lclk = 1'b0;
  logic        wr, rd, lock, resync, rmc, rxe;
  logic        rce, rxen, ctype, tmo, pin, oe;
  logic [5:0]  addr;
  logic [15:0] wdata, rdata, st, mo, w;
  logic [2:0]  chn, chen, v;
  logic [1:0]  wsz;
  logic        exp_rst = 1'b1;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cnt = 0;
  // tri-state pin with a pull-up
  wire         pin_lvl = oe ? pin : 1'b1;

  always #5 clk_i = ~clk_i;
  always #62.5 lclk = ~lclk;
  always @(negedge clk_i) if (!pin_lvl) cnt++;

  asm_status_mode u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .lock_i(lock), .resync_i(resync),
    .regmap_crc_changed_i(rmc), .rx_crc_err_i(rxe), .ch_new_i(chn),
    .ch_en_i(chen), .regmap_crc_en_o(rce), .rx_crc_check_en_o(rxen),
    .crc_type_o(ctype), .word_size_select_o(wsz), .timeout_en_o(tmo),
    .sample_ready_pin_o(pin), .sample_ready_pin_oe_o(oe));

  asm_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr),
    .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_st(logic [15:0] m, logic r);
    return {4'h0, m[11], r, m[9:8], 8'h00};
  endfunction

  // events paced by the link clock, applied on clock falling edges
  task automatic ev(input logic [2:0] c);
    @(posedge lclk);
    @(negedge clk_i);
    {lock, resync, rmc, rxe, chn} = {4'hF, c};
    @(posedge lclk);
    @(negedge clk_i);
    {resync, rmc, rxe, chn} = '0;
    repeat (6) @(negedge clk_i);
  endtask

  initial begin
    {lock, resync, rmc, rxe, chn} = '0;
    chen = 3'b111;
    v = 3'($urandom(32'hd600c7d3));
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    u_host.rd(ASM_ADDR_STATUS, st);
    chk(st, 16'h0500);
    u_host.rd(ASM_ADDR_MODE, mo);
    chk(mo, 16'h0510);
    chk({10'h0, rce, rxen, ctype, wsz, tmo}, 16'h0003);
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      u_host.wr(ASM_ADDR_MODE, w);
      exp_rst &= w[10];
      @(negedge clk_i);
      chk({10'h0, rce, rxen, ctype, wsz, tmo},
          {10'h0, w[13:11], w[9:8], w[4]});
      u_host.rd(ASM_ADDR_MODE, mo);
      chk(mo, w & ASM_MODE_WMASK);
      u_host.rd(ASM_ADDR_STATUS, st);
      chk(st, exp_st(w, exp_rst));
    end
    // checks on, pulse format, any enabled channel drives the pin
    w = 16'h3115;
    exp_rst = 1'b0;
    u_host.wr(ASM_ADDR_MODE, w);
    u_host.rd(ASM_ADDR_STATUS, st);
    v = v | 3'b001;
    cnt = 0;
    ev(v);
    chk(16'(cnt), 16'(ASM_PULSE_CYC));
    u_host.rd(ASM_ADDR_STATUS, st);
    chk(st, exp_st(w, exp_rst) | 16'hF000 | 16'(v));
    u_host.rd(ASM_ADDR_STATUS, st);
    chk(st, exp_st(w, exp_rst) | 16'h8000);
    // level format, pin waits for the last enabled channel
    w = 16'h3110;
    u_host.wr(ASM_ADDR_MODE, w);
    @(negedge clk_i);
    chen = 3'b011;
    ev(3'b001);
    chk(16'(pin_lvl), 16'h0001);
    ev(3'b010);
    chk(16'(pin_lvl), 16'h0000);
    // floating idle pin, input checksum check off
    w = 16'h2112;
    u_host.wr(ASM_ADDR_MODE, w);
    u_host.rd(ASM_ADDR_STATUS, st);
    chk(st, exp_st(w, exp_rst) | 16'hF003);
    repeat (3) @(negedge clk_i);
    chk(16'(oe), 16'h0000);
    ev(3'b010);
    chk(16'(pin_lvl), 16'h0001);
    u_host.rd(ASM_ADDR_STATUS, st);
    chk(st, exp_st(w, exp_rst) | 16'hE002);
    // leading source, pulse format
    w = 16'h3119;
    u_host.wr(ASM_ADDR_MODE, w);
    cnt = 0;
    ev(3'b001);
    chk(16'(cnt), 16'(ASM_PULSE_CYC));
    // second reset brings the reset flag back
    lock = 1'b0;
    rstn_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    u_host.rd(ASM_ADDR_STATUS, st);
    chk(st, ASM_STATUS_RESET);
    u_host.rd(ASM_ADDR_MODE, mo);
    chk(mo, ASM_MODE_RESET);
    complete_run();
  end
endmodule
